// ===== adc_range_control_loop.sv
//
// Contract
// - immediate threshold crossing raises attenuation now, above averaged path, below host load
// - immediate trigger starts a programmable sample holdoff
// - averaged path high-pass filters out converter DC
// - magnitudes integrate and dump, 1 to 65536 samples
// - dump right-shifted by programmable power of two
// - averaged decisions only at period end
// - above upper threshold: add increase step
// - below lower threshold: subtract decrease step
// - between thresholds: add signed bias, if enabled
// - accumulator steps clamped to limits, host load is not; top bits drive outputs
// - top three accumulator bits: 0 to 42 dB in 6 dB steps
// - gain bits delayed 1 to 256 clocks
// - 3-bit code addresses 8x8-bit attenuator pattern table
// - 16-bit attenuation bus updated every clock
// - nibble mapping: four 4-bit or two 8-bit channels
// - immediate detector ignores the timers
// - slot of 1 to 65536 ticks, reloads at end or sync
// - delay reloads with slot; first period starts at its end
// - period length and periods per slot are counted
// - host writes accumulator; reads it, DC and average
// - digital gain matches each analog step
//
`timescale 1ns/100ps
module adc_range_control_loop
    import rc_pkg::*;
(
    input  wire logic                       SYS_CLK,
    input  wire logic                       RESET,
    input  wire logic signed [SAMPLE_W-1:0] SAMPLE_DATA,
    input  wire logic                       SAMPLE_VALID,
    input  wire logic                       SLOT_SYNC,
    input  wire rc_cfg_t                    CFG,
    input  wire logic                       ACC_LOAD,
    input  wire logic        [ACC_W-1:0]    ACC_LOAD_VALUE,
    output logic             [BUS_W-1:0]    ATTEN_CTRL_BUS,
    output logic             [CODE_W-1:0]   GAIN_SHIFT_CODE,
    output logic             [ACC_W-1:0]    ACC_VALUE,
    output logic signed      [SAMPLE_W-1:0] DC_OFFSET,
    output logic             [SAMPLE_W-1:0] AVG_MAGNITUDE,
    output logic                            IMM_HOLDOFF,
    output logic                            AVG_ACTIVE
);

    ////////////////////////////////////////
    // declarations

    rc_state_t                  state_reg;
    rc_state_t                  state_next;

    logic [ACC_W-1:0]           acc_reg;
    logic [ACC_W-1:0]           acc_next;
    logic [DC_ACC_W-1:0]        dc_acc_reg;
    logic [INTEG_W-1:0]         integ_reg;
    logic [SAMPLE_W-1:0]        avg_mag_reg;
    logic [BUS_W-1:0]           bus_reg;
    logic [BUS_W-1:0]           bus_next;

    logic [SAMPLE_W-1:0]        raw_abs;
    logic                       imm_fire;
    logic                       holdoff_zero;

    logic signed [SAMPLE_W-1:0] dc_int;
    logic signed [ABS_W-1:0]    hpf_out;
    logic [ABS_W-1:0]           hpf_abs;
    logic signed [47:0]         dc_incr;

    logic [INTEG_W-1:0]         dump_total;
    logic [INTEG_W-1:0]         dump_scaled;
    logic                       above_upper;
    logic                       below_lower;
    logic signed [ACC_W:0]      avg_delta;

    logic                       slot_tick;
    logic                       slot_reload;
    logic                       slot_zero;
    logic                       delay_zero;
    logic                       delay_done;
    logic                       integ_zero;
    logic                       period_zero;
    logic                       dump;
    logic                       next_period;

    logic [CODE_W-1:0]          atten_code;
    logic [LUT_W-1:0]           lut_word;
    logic [CODE_W-1:0]          gain_dly_code;

    ////////////////////////////////////////
    // clamp

    function automatic logic [ACC_W-1:0] clamp_add(
        input logic [ACC_W-1:0]    acc,
        input logic signed [ACC_W:0] delta,
        input logic [ACC_W-1:0]    lo,
        input logic [ACC_W-1:0]    hi
    );
        logic signed [ACC_W+1:0] sum;
        sum = $signed({2'b00, acc}) + (ACC_W+2)'(delta);
        if (sum > $signed({2'b00, hi})) begin
            clamp_add = hi;
        end else if (sum < $signed({2'b00, lo})) begin
            clamp_add = lo;
        end else begin
            clamp_add = sum[ACC_W-1:0];
        end
    endfunction : clamp_add

    ////////////////////////////////////////
    // immediate detector

    assign raw_abs = SAMPLE_DATA[SAMPLE_W-1] ? SAMPLE_W'(-SAMPLE_DATA)
                                              : SAMPLE_W'(SAMPLE_DATA);

    // holdoff lets the loop settle between steps
    assign imm_fire = SAMPLE_VALID && holdoff_zero && !ACC_LOAD
                      && (raw_abs > CFG.imm_thresh);

    down_counter #(.W(CNT_W)) u_holdoff (
        .clk        (SYS_CLK),
        .rst        (RESET),
        .load       (imm_fire),
        .load_value (CFG.holdoff_len),
        .dec        (SAMPLE_VALID),
        .count      (),
        .zero       (holdoff_zero)
    );

    ////////////////////////////////////////
    // dc block

    assign dc_int  = $signed(dc_acc_reg[DC_ACC_W-1:HPF_FRAC_W]);
    assign hpf_out = ABS_W'(SAMPLE_DATA) - ABS_W'(dc_int);
    assign hpf_abs = hpf_out[ABS_W-1] ? ABS_W'(-hpf_out) : ABS_W'(hpf_out);
    // zero shift acts as one
    assign dc_incr = (48'(hpf_out) <<< HPF_FRAC_W)
                     >>> ((CFG.hpf_shift == '0) ? 4'h1 : CFG.hpf_shift);

    always_ff @(posedge SYS_CLK or posedge RESET) begin
        if (RESET) begin
            dc_acc_reg <= DC_RESET;
        end else if (SAMPLE_VALID) begin
            dc_acc_reg <= dc_acc_reg + DC_ACC_W'(dc_incr);
        end
    end

    ////////////////////////////////////////
    // timers

    assign slot_tick   = CFG.slot_on_clk ? 1'b1 : SAMPLE_VALID;
    assign slot_reload = SLOT_SYNC || (slot_tick && slot_zero);

    down_counter #(.W(CNT_W)) u_slot (
        .clk        (SYS_CLK),
        .rst        (RESET),
        .load       (slot_reload),
        .load_value (CFG.slot_len_m1),
        .dec        (slot_tick),
        .count      (),
        .zero       (slot_zero)
    );

    down_counter #(.W(CNT_W)) u_delay (
        .clk        (SYS_CLK),
        .rst        (RESET),
        .load       (slot_reload),
        .load_value (CFG.delay_len),
        .dec        (slot_tick && state_reg == ST_DELAY),
        .count      (),
        .zero       (delay_zero)
    );

    assign delay_done  = (state_reg == ST_DELAY) && delay_zero && !slot_reload;
    assign dump        = (state_reg == ST_INTEG) && SAMPLE_VALID && integ_zero
                         && !slot_reload;
    assign next_period = dump && !period_zero;

    down_counter #(.W(CNT_W)) u_integ (
        .clk        (SYS_CLK),
        .rst        (RESET),
        .load       (delay_done || next_period),
        .load_value (CFG.int_len_m1),
        .dec        (SAMPLE_VALID && state_reg == ST_INTEG),
        .count      (),
        .zero       (integ_zero)
    );

    down_counter #(.W(CNT_W)) u_period (
        .clk        (SYS_CLK),
        .rst        (RESET),
        .load       (delay_done),
        .load_value (CFG.periods_m1),
        .dec        (dump),
        .count      (),
        .zero       (period_zero)
    );

    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            ST_IDLE: begin
                if (slot_reload) begin
                    state_next = ST_DELAY;
                end
            end
            ST_DELAY: begin
                if (slot_reload) begin
                    state_next = ST_DELAY;
                end else if (delay_done) begin
                    state_next = ST_INTEG;
                end
            end
            ST_INTEG: begin
                // sync drops the partial sum
                if (slot_reload) begin
                    state_next = ST_DELAY;
                end else if (dump && period_zero) begin
                    state_next = ST_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge SYS_CLK or posedge RESET) begin
        if (RESET) begin
            state_reg <= ST_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    ////////////////////////////////////////
    // integrate and dump

    assign dump_total  = integ_reg + INTEG_W'(hpf_abs);
    assign dump_scaled = dump_total >> CFG.dump_shift;
    assign above_upper = dump_scaled > INTEG_W'(CFG.upper_thresh);
    assign below_lower = dump_scaled < INTEG_W'(CFG.lower_thresh);

    always_ff @(posedge SYS_CLK or posedge RESET) begin
        if (RESET) begin
            integ_reg <= INTEG_RESET;
        end else if (delay_done || dump || slot_reload) begin
            integ_reg <= INTEG_RESET;
        end else if (SAMPLE_VALID && state_reg == ST_INTEG) begin
            integ_reg <= dump_total;
        end
    end

    // saturated for small shifts
    always_ff @(posedge SYS_CLK or posedge RESET) begin
        if (RESET) begin
            avg_mag_reg <= '0;
        end else if (dump) begin
            avg_mag_reg <= (dump_scaled > INTEG_W'({SAMPLE_W{1'b1}}))
                           ? {SAMPLE_W{1'b1}} : dump_scaled[SAMPLE_W-1:0];
        end
    end

    ////////////////////////////////////////
    // attenuation accumulator

    always_comb begin
        if (above_upper) begin
            avg_delta = $signed({1'b0, CFG.inc_step});
        end else if (below_lower) begin
            avg_delta = -$signed({1'b0, CFG.dec_step});
        end else if (CFG.bias_en) begin
            avg_delta = (ACC_W+1)'($signed(CFG.bias));
        end else begin
            avg_delta = '0;
        end
    end

    // host load, then immediate, then averaged
    always_comb begin
        acc_next = acc_reg;
        if (ACC_LOAD) begin
            acc_next = ACC_LOAD_VALUE;
        end else if (imm_fire) begin
            acc_next = clamp_add(acc_reg, $signed({1'b0, CFG.imm_step}),
                                 CFG.acc_min, CFG.acc_max);
        end else if (dump) begin
            acc_next = clamp_add(acc_reg, avg_delta,
                                 CFG.acc_min, CFG.acc_max);
        end
    end

    always_ff @(posedge SYS_CLK or posedge RESET) begin
        if (RESET) begin
            acc_reg <= ACC_RESET;
        end else begin
            acc_reg <= acc_next;
        end
    end

    ////////////////////////////////////////
    // output bus

    assign atten_code = acc_reg[ACC_W-1 -: CODE_W];
    assign lut_word   = CFG.lut[atten_code];

    // gain delayed to meet the analog step
    gain_delay_mem #(.W(CODE_W), .DEPTH(DLY_DEPTH), .AW(DLY_AW)) u_gain_dly (
        .clk     (SYS_CLK),
        .rst     (RESET),
        .wr_data (atten_code),
        .dly_m1  (CFG.gain_dly_m1),
        .rd_data (gain_dly_code)
    );

    always_comb begin
        bus_next = BUS_RESET;
        for (int n = 0; n < NIB_NUM; n++) begin
            unique case (CFG.nib_sel[n])
                NIB_ZERO:   bus_next[n*NIB_W +: NIB_W] = '0;
                NIB_LUT_LO: bus_next[n*NIB_W +: NIB_W] = lut_word[NIB_W-1:0];
                NIB_LUT_HI: bus_next[n*NIB_W +: NIB_W] = lut_word[LUT_W-1:NIB_W];
                NIB_GAIN:   bus_next[n*NIB_W +: NIB_W] = NIB_W'(gain_dly_code);
            endcase
        end
    end

    always_ff @(posedge SYS_CLK or posedge RESET) begin
        if (RESET) begin
            bus_reg <= BUS_RESET;
        end else begin
            bus_reg <= bus_next;
        end
    end

    ////////////////////////////////////////
    // outputs

    assign ATTEN_CTRL_BUS  = bus_reg;
    assign GAIN_SHIFT_CODE = gain_dly_code;
    assign ACC_VALUE       = acc_reg;
    assign DC_OFFSET       = dc_int;
    assign AVG_MAGNITUDE   = avg_mag_reg;
    assign IMM_HOLDOFF     = !holdoff_zero;
    assign AVG_ACTIVE      = (state_reg == ST_INTEG);

endmodule : adc_range_control_loop

// ===== rc_pkg.sv
package rc_pkg;

    localparam int SAMPLE_W    = 16;
    localparam int ABS_W       = SAMPLE_W + 1;
    localparam int CNT_W       = 16;
    localparam int INTEG_W     = ABS_W + CNT_W;
    localparam int SHIFT_W     = 6;
    localparam int HPF_FRAC_W  = 16;
    localparam int HPF_K_W     = 4;
    localparam int DC_ACC_W    = SAMPLE_W + HPF_FRAC_W;
    localparam int ACC_W       = 16;
    localparam int CODE_W      = 3;
    localparam int LUT_DEPTH   = 8;
    localparam int LUT_W       = 8;
    localparam int BUS_W       = 16;
    localparam int NIB_W       = 4;
    localparam int NIB_NUM     = BUS_W / NIB_W;
    localparam int DLY_DEPTH   = 256;
    localparam int DLY_AW      = 8;

    localparam logic [ACC_W-1:0]    ACC_RESET   = 16'h0000;
    localparam logic [BUS_W-1:0]    BUS_RESET   = 16'h0000;
    localparam logic [CODE_W-1:0]   CODE_RESET  = 3'h0;
    localparam logic [DC_ACC_W-1:0] DC_RESET    = 32'h0;
    localparam logic [INTEG_W-1:0]  INTEG_RESET = 33'h0;

    // output nibble sources
    localparam logic [1:0] NIB_ZERO    = 2'h0;
    localparam logic [1:0] NIB_LUT_LO  = 2'h1;
    localparam logic [1:0] NIB_LUT_HI  = 2'h2;
    localparam logic [1:0] NIB_GAIN    = 2'h3;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_DELAY = 3'b010,
        ST_INTEG = 3'b100
    } rc_state_t;

    typedef struct packed {
        logic [SAMPLE_W-1:0]              imm_thresh;
        logic [ACC_W-1:0]                 imm_step;
        logic [CNT_W-1:0]                 holdoff_len;
        logic [HPF_K_W-1:0]               hpf_shift;
        logic [CNT_W-1:0]                 int_len_m1;
        logic [SHIFT_W-1:0]               dump_shift;
        logic [SAMPLE_W-1:0]              upper_thresh;
        logic [SAMPLE_W-1:0]              lower_thresh;
        logic [ACC_W-1:0]                 inc_step;
        logic [ACC_W-1:0]                 dec_step;
        logic [ACC_W-1:0]                 bias;
        logic                             bias_en;
        logic [ACC_W-1:0]                 acc_max;
        logic [ACC_W-1:0]                 acc_min;
        logic [DLY_AW-1:0]                gain_dly_m1;
        logic                             slot_on_clk;
        logic [CNT_W-1:0]                 slot_len_m1;
        logic [CNT_W-1:0]                 delay_len;
        logic [CNT_W-1:0]                 periods_m1;
        logic [LUT_DEPTH-1:0][LUT_W-1:0]  lut;
        logic [NIB_NUM-1:0][1:0]          nib_sel;
    } rc_cfg_t;

endpackage : rc_pkg

// ===== down_counter.sv
`timescale 1ns/100ps
module down_counter
    import rc_pkg::*;
#(
    parameter int W = CNT_W
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic         load,
    input  wire logic [W-1:0] load_value,
    input  wire logic         dec,
    output logic      [W-1:0] count,
    output logic              zero
);

    logic [W-1:0] count_reg;

    // load wins; parks at zero
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            count_reg <= '0;
        end else if (load) begin
            count_reg <= load_value;
        end else if (dec && count_reg != '0) begin
            count_reg <= count_reg - W'(1);
        end
    end

    assign count = count_reg;
    assign zero  = (count_reg == '0);

endmodule : down_counter

// ===== gain_delay_mem.sv
`timescale 1ns/100ps
module gain_delay_mem
    import rc_pkg::*;
#(
    parameter int W     = CODE_W,
    parameter int DEPTH = DLY_DEPTH,
    parameter int AW    = DLY_AW
) (
    input  wire logic          clk,
    input  wire logic          rst,
    input  wire logic [W-1:0]  wr_data,
    input  wire logic [AW-1:0] dly_m1,
    output logic      [W-1:0]  rd_data
);

    logic [W-1:0]  mem [DEPTH];
    logic [AW-1:0] wr_ptr_reg;
    logic [AW-1:0] rd_addr;
    logic [W-1:0]  rd_data_reg;

    assign rd_addr = wr_ptr_reg - dly_m1;

    // cleared so no stale gain after start-up
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem[i] <= '0;
            end
            wr_ptr_reg <= '0;
        end else begin
            mem[wr_ptr_reg] <= wr_data;
            wr_ptr_reg      <= wr_ptr_reg + AW'(1);
        end
    end

    // write-through for the one-clock setting
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rd_data_reg <= '0;
        end else if (rd_addr == wr_ptr_reg) begin
            rd_data_reg <= wr_data;
        end else begin
            rd_data_reg <= mem[rd_addr];
        end
    end

    assign rd_data = rd_data_reg;

endmodule : gain_delay_mem

// ===== adc_range_control_loop_sva.sv
`timescale 1ns/100ps
module adc_range_control_loop_sva
    import rc_pkg::*;
(
    input wire logic                       SYS_CLK,
    input wire logic                       RESET,
    input wire logic signed [SAMPLE_W-1:0] SAMPLE_DATA,
    input wire logic                       SAMPLE_VALID,
    input wire logic                       SLOT_SYNC,
    input wire rc_cfg_t                    CFG,
    input wire logic                       ACC_LOAD,
    input wire logic        [ACC_W-1:0]    ACC_LOAD_VALUE,
    input wire logic        [BUS_W-1:0]    ATTEN_CTRL_BUS,
    input wire logic        [CODE_W-1:0]   GAIN_SHIFT_CODE,
    input wire logic        [ACC_W-1:0]    ACC_VALUE,
    input wire logic                       IMM_HOLDOFF,
    input wire logic                       AVG_ACTIVE
);
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (RESET);
    ////////////////////////////////////////
    logic [SAMPLE_W:0]  mag;
    logic [ACC_W:0]     sum;
    logic [ACC_W-1:0]   imm_exp;
    logic               imm_fire;
    logic [CNT_W:0]     held_cnt;
    logic [CNT_W:0]     since_sync;
    logic [1:0]         up_cnt;
    logic [CODE_W-1:0]  hist [0:DLY_DEPTH];

    function automatic logic [BUS_W-1:0] bus_map(input rc_cfg_t c, input logic [2:0] code,
                                                 input logic [2:0] g);
        logic [BUS_W-1:0] b;
        b = '0;
        for (int k = 0; k < NIB_NUM; k++) begin
            case (c.nib_sel[k])
                NIB_LUT_LO: b[k*4 +: 4] = c.lut[code][3:0];
                NIB_LUT_HI: b[k*4 +: 4] = c.lut[code][7:4];
                NIB_GAIN:   b[k*4 +: 4] = {1'b0, g};
                default:    b[k*4 +: 4] = 4'h0;
            endcase
        end
        return b;
    endfunction : bus_map

    // 17 bits: most negative sample cannot wrap
    always_comb begin
        mag = SAMPLE_DATA[SAMPLE_W-1] ? ~{1'b1, SAMPLE_DATA} + 17'h1 : {1'b0, SAMPLE_DATA};
        sum = {1'b0, ACC_VALUE} + {1'b0, CFG.imm_step};
        imm_exp = (sum > {1'b0, CFG.acc_max}) ? CFG.acc_max : sum[ACC_W-1:0];
        if (imm_exp < CFG.acc_min) begin
            imm_exp = CFG.acc_min;
        end
        imm_fire = SAMPLE_VALID && !IMM_HOLDOFF && !ACC_LOAD && (mag > {1'b0, CFG.imm_thresh});
    end

    always_ff @(posedge SYS_CLK or posedge RESET) begin
        if (RESET) begin
            held_cnt   <= '0;
            since_sync <= '1;
            up_cnt     <= 2'h0;
        end else begin
            held_cnt   <= !IMM_HOLDOFF ? '0 : held_cnt + (SAMPLE_VALID ? 17'h1 : 17'h0);
            since_sync <= SLOT_SYNC ? 17'h1 : since_sync + (&since_sync ? 17'h0 : 17'h1);
            up_cnt     <= up_cnt + (up_cnt[1] ? 2'h0 : 2'h1);
        end
    end

    // deep history: any delay checkable
    always_ff @(posedge SYS_CLK or posedge RESET) begin
        if (RESET) begin
            for (int k = 0; k <= DLY_DEPTH; k++) hist[k] <= '0;
        end else begin
            hist[0] <= ACC_VALUE[ACC_W-1 -: CODE_W];
            for (int k = 1; k <= DLY_DEPTH; k++) hist[k] <= hist[k-1];
        end
    end
    ////////////////////////////////////////
    load_acc_a: assert property (ACC_LOAD |=> ACC_VALUE == $past(ACC_LOAD_VALUE))
        else $error("load lost");
    imm_raise_a: assert property (imm_fire |=> ACC_VALUE == $past(imm_exp))
        else $error("immediate step wrong");
    holdoff_set_a: assert property (imm_fire && CFG.holdoff_len != 16'h0 |=> IMM_HOLDOFF)
        else $error("holdoff not started");
    holdoff_len_a: assert property ($fell(IMM_HOLDOFF) |-> held_cnt == {1'b0, CFG.holdoff_len})
        else $error("holdoff length wrong");
    bus_map_a: assert property (up_cnt == 2'h2 |-> ATTEN_CTRL_BUS ==
        bus_map($past(CFG), $past(ACC_VALUE[15:13]), $past(GAIN_SHIFT_CODE)))
        else $error("bus map wrong");
    gain_delay_a: assert property (GAIN_SHIFT_CODE == hist[CFG.gain_dly_m1])
        else $error("gain code delay wrong");
    sync_idle_a: assert property (SLOT_SYNC |=> !AVG_ACTIVE)
        else $error("sync ignored");
    delay_start_a: assert property ($rose(AVG_ACTIVE) && CFG.slot_on_clk &&
        since_sync <= {1'b0, CFG.delay_len} + 17'h2 |-> since_sync == {1'b0, CFG.delay_len} + 17'h2)
        else $error("early integration");
    quiet_acc_a: assert property (!ACC_LOAD && !imm_fire && !AVG_ACTIVE |=> $stable(ACC_VALUE))
        else $error("acc moved");
endmodule : adc_range_control_loop_sva

bind adc_range_control_loop adc_range_control_loop_sva chk (.SYS_CLK(SYS_CLK), .RESET(RESET),
    .SAMPLE_DATA(SAMPLE_DATA), .SAMPLE_VALID(SAMPLE_VALID), .SLOT_SYNC(SLOT_SYNC), .CFG(CFG),
    .ACC_LOAD(ACC_LOAD), .ACC_LOAD_VALUE(ACC_LOAD_VALUE), .ATTEN_CTRL_BUS(ATTEN_CTRL_BUS),
    .GAIN_SHIFT_CODE(GAIN_SHIFT_CODE), .ACC_VALUE(ACC_VALUE), .IMM_HOLDOFF(IMM_HOLDOFF),
    .AVG_ACTIVE(AVG_ACTIVE));

// ===== adc_atten_model.sv
`timescale 1ns/100ps
module adc_atten_model
    import rc_pkg::*;
(
    input  wire logic                clk,
    input  wire logic [SAMPLE_W-1:0] amp,
    input  wire logic [SAMPLE_W-1:0] dc,
    input  wire logic [BUS_W-1:0]    atten_bus,
    output logic      [SAMPLE_W-1:0] sample,
    output logic                     valid,
    output logic      [BUS_W-1:0]    pattern
);
    logic phase = 1'b0;
    ////////////////////////////////////////
    // alternating sign around offset
    initial valid = 1'b1;
    always @(posedge clk) begin
        phase  <= ~phase;
        sample <= dc + (phase ? amp : -amp);
    end
    // latched every clock
    always @(posedge clk) begin
        pattern <= atten_bus;
    end
endmodule : adc_atten_model

// ===== test_adc_range_control_loop.sv
`timescale 1ns/100ps
module test_adc_range_control_loop
    import rc_pkg::*;
;
    logic                sys_clk = 1'b0;
    logic                reset = 1'b1;
    logic                slot_sync = 1'b0;
    logic                acc_load = 1'b0;
    logic [ACC_W-1:0]    load_val = '0;
    logic [SAMPLE_W-1:0] amp = '0;
    logic [SAMPLE_W-1:0] dc = '0;
    logic [SAMPLE_W-1:0] sample;
    logic                valid;
    logic [BUS_W-1:0]    pattern;
    logic [BUS_W-1:0]    atten_bus;
    logic [CODE_W-1:0]   gain_code;
    logic [ACC_W-1:0]    acc_value;
    logic [SAMPLE_W-1:0] dc_off;
    logic [SAMPLE_W-1:0] avg_mag;
    logic                holdoff;
    logic                avg_active;
    rc_cfg_t             cfg;
    int                  err_total = 0;
    int                  cmp_count = 0;
    int                  n;

    always #10 sys_clk = ~sys_clk;

    adc_range_control_loop dut (.SYS_CLK(sys_clk), .RESET(reset), .SAMPLE_DATA(sample),
        .SAMPLE_VALID(valid), .SLOT_SYNC(slot_sync), .CFG(cfg), .ACC_LOAD(acc_load),
        .ACC_LOAD_VALUE(load_val), .ATTEN_CTRL_BUS(atten_bus), .GAIN_SHIFT_CODE(gain_code),
        .ACC_VALUE(acc_value), .DC_OFFSET(dc_off), .AVG_MAGNITUDE(avg_mag),
        .IMM_HOLDOFF(holdoff), .AVG_ACTIVE(avg_active));
    adc_atten_model adc (.clk(sys_clk), .amp(amp), .dc(dc), .atten_bus(atten_bus),
        .sample(sample), .valid(valid), .pattern(pattern));
    ////////////////////////////////////////
    task automatic summarize();
        if (err_total == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : summarize

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic tick(input int k);
        repeat (k) @(negedge sys_clk);
    endtask : tick

    function automatic logic [15:0] mon(input int sel);
        return sel == 0 ? acc_value : (sel == 1 ? {13'h0, gain_code} : {15'h0, avg_active});
    endfunction : mon

    // bounded wait
    task automatic wait_eq(input int sel, input logic [15:0] exp, input int lim, output int k);
        k = 0;
        while (mon(sel) !== exp && k < lim) begin
            tick(1);
            k++;
        end
        if (mon(sel) !== exp) begin
            err_total++;
            summarize();
        end
    endtask : wait_eq

    task automatic load(input logic [ACC_W-1:0] v);
        acc_load = 1'b1;
        load_val = v;
        tick(1);
        acc_load = 1'b0;
    endtask : load

    task automatic do_reset();
        reset = 1'b1;
        tick(3);
        reset = 1'b0;
    endtask : do_reset

    task automatic gain_delay();
        load(16'he000);
        wait_eq(1, 16'h0007, 300, n);
        check(16'(n), 16'(cfg.gain_dly_m1) + 16'h1);
    endtask : gain_delay

    task automatic lut_loop(input logic b);
        logic [3:0] lo, hi;
        logic [15:0] e;
        for (int c = 0; c < LUT_DEPTH; c++) begin
            load({3'(c), 13'h0});
            tick(int'(cfg.gain_dly_m1) + 4);
            lo = 4'(c) + 4'h8;
            hi = 4'(c) ^ 4'h5;
            e = b ? {lo, 4'h0, hi, lo} : {1'b0, 3'(c), hi, lo, 4'h0};
            check(atten_bus, e);
            check(pattern, e);
            check({13'h0, gain_code}, 16'(c));
        end
    endtask : lut_loop

    task automatic avg_row(input logic [15:0] a, ld, ea, input logic [5:0] ds, input logic be);
        logic [18:0] ev;
        cfg.dump_shift = ds;
        cfg.bias_en = be;
        amp = a;
        slot_sync = 1'b1;
        load(ld);
        slot_sync = 1'b0;
        wait_eq(2, 16'h1, 20, n);
        check(16'(n), 16'(cfg.delay_len) + 16'h1);
        tick(4);
        check(acc_value, ld);
        wait_eq(2, 16'h0, 40, n);
        check(16'(n), 16'd12);
        check(acc_value, ea);
        ev = ({3'h0, a} << 3) >> ds;
        check({15'h0, avg_mag + 16'h3 >= ev[15:0] && avg_mag <= ev[15:0] + 16'h3}, 16'h1);
    endtask : avg_row
    ////////////////////////////////////////
    initial begin
        cfg = '0;
        cfg.imm_thresh = 16'h7000;
        cfg.imm_step = 16'h2000;
        cfg.holdoff_len = 16'h4;
        cfg.hpf_shift = 4'hf;
        cfg.int_len_m1 = 16'h7;
        cfg.upper_thresh = 16'hffff;
        cfg.inc_step = 16'h0100;
        cfg.dec_step = 16'h0040;
        cfg.bias = 16'hffe0;
        cfg.acc_max = 16'hffff;
        cfg.slot_on_clk = 1'b1;
        cfg.slot_len_m1 = 16'h00ff;
        cfg.delay_len = 16'h3;
        cfg.periods_m1 = 16'h1;
        for (int i = 0; i < LUT_DEPTH; i++) begin
            cfg.lut[i] = {4'(i) ^ 4'h5, 4'(i) + 4'h8};
        end
        cfg.nib_sel = {NIB_GAIN, NIB_LUT_HI, NIB_LUT_LO, NIB_ZERO};
        do_reset();
        gain_delay();
        lut_loop(1'b0);
        cfg.gain_dly_m1 = 8'hff;
        cfg.nib_sel = {NIB_LUT_LO, NIB_ZERO, NIB_LUT_HI, NIB_LUT_LO};
        do_reset();
        gain_delay();
        lut_loop(1'b1);
        // sync held: averaged path frozen
        cfg.acc_max = 16'he000;
        slot_sync = 1'b1;
        load(16'h0000);
        amp = 16'h7800;
        wait_eq(0, 16'h2000, 8, n);
        check({15'h0, holdoff}, 16'h1);
        wait_eq(0, 16'h4000, 8, n);
        check(16'(n), 16'h5);
        wait_eq(0, 16'he000, 60, n);
        tick(12);
        check(acc_value, 16'he000);
        amp = 16'h7000;
        load(16'h0000);
        tick(12);
        check(acc_value, 16'h0000);
        amp = 16'h0000;
        dc = 16'h8fff;
        wait_eq(0, 16'h2000, 8, n);
        dc = 16'h0000;
        slot_sync = 1'b0;
        cfg.upper_thresh = 16'h0800;
        cfg.lower_thresh = 16'h0400;
        cfg.acc_max = 16'hffff;
        avg_row(16'h1000, 16'h8000, 16'h8200, 6'h3, 1'b0);
        avg_row(16'h1400, 16'h8000, 16'h8200, 6'h4, 1'b0);
        avg_row(16'h0100, 16'h8000, 16'h7f80, 6'h3, 1'b0);
        avg_row(16'h0600, 16'h8000, 16'h7fc0, 6'h3, 1'b1);
        avg_row(16'h0600, 16'h8000, 16'h8000, 6'h3, 1'b0);
        cfg.acc_max = 16'h8100;
        avg_row(16'h1000, 16'h8080, 16'h8100, 6'h3, 1'b0);
        cfg.acc_max = 16'hffff;
        cfg.slot_on_clk = 1'b0;
        avg_row(16'h0100, 16'h0040, 16'h0000, 6'h3, 1'b0);
        cfg.hpf_shift = 4'h4;
        amp = 16'h0000;
        dc = 16'h0400;
        tick(300);
        check({15'h0, dc_off >= 16'h03fc && dc_off <= 16'h0400}, 16'h1);
        summarize();
    end
endmodule : test_adc_range_control_loop
